// ---- hdl/fssp_fuse_store.sv ----
// Purpose: Non-volatile fuse array holding logic, polarity and signature fuses.
// Assumes: Contents survive reset; the array starts blank.
// Notes: Erase clears every fuse in one cycle.
`timescale 1ns/1ps
`default_nettype none
module fssp_fuse_store
   import fssp_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   fssp_store_if.store st
);
   logic [FUSE_TOTAL-1:0] fuseBits_ff = '0;   // Fuse cells, not touched by reset
   logic [FUSE_TOTAL-1:0] nxt_fuseBits;       // Next fuse contents

   // Erase or program one fuse
   always_comb begin
      nxt_fuseBits = fuseBits_ff;
      if (st.erase) begin
         nxt_fuseBits = '0;
      end else if (st.wrEn && (st.addr < EXT_LIMIT)) begin
         nxt_fuseBits[st.addr] = st.wrData;
      end
   end

   // Register the array
   always_ff @(posedge mclk) begin
      fuseBits_ff <= nxt_fuseBits;
   end

   // Read ports
   assign st.rdData = (st.addr < EXT_LIMIT) ? fuseBits_ff[st.addr] : 1'b0;
   assign st.sig = fuseBits_ff[FUSE_TOTAL-1 -: SIG_BITS];
   assign st.pol = fuseBits_ff[POL_BASE +: NUM_REGS];

   // Checks
   a_erase_blanks_sig: assert property (@(posedge mclk) disable iff (rst)
      st.erase |=> (st.sig == SIG_BLANK))
      else $error("signature not blank after erase");
   a_write_stores_bit: assert property (@(posedge mclk) disable iff (rst)
      (st.wrEn && !st.erase && st.addr < EXT_LIMIT) |=> (fuseBits_ff[$past(st.addr)] == $past(st.wrData)))
      else $error("fuse write not stored");
endmodule
`default_nettype wire

// ---- hdl/fssp_pkg.sv ----
// Purpose: Shared constants and types for the fuse, signature, security and preload block.
// Assumes: One 50 MHz clock, synchronous active-high reset.
// Notes: Fuse addresses are bit indices into the extended fuse map.
package fssp_pkg;
   localparam int unsigned CLK_PERIOD_NS = 20;     // 50 MHz clock period
   localparam int unsigned PWRUP_TIME_NS = 1000;   // Power-up reset, longest time
   localparam int unsigned PWRUP_CYCLES = PWRUP_TIME_NS / CLK_PERIOD_NS; // Rounded down
   localparam int unsigned POR_W = 6;              // Power-up counter width
   localparam logic [POR_W-1:0] POR_LAST = POR_W'(PWRUP_CYCLES - 1); // Final count
   localparam int unsigned ADDR_W = 13;            // Fuse address width
   localparam int unsigned FUSE_TOTAL = 5892;      // Extended map size
   localparam int unsigned FUSE_STD = 5828;        // Standard map size
   localparam int unsigned SIG_BITS = 64;          // User signature size
   localparam logic [ADDR_W-1:0] SIG_BASE = 13'h16C4;  // First signature fuse (5828)
   localparam logic [ADDR_W-1:0] STD_LIMIT = 13'h16C4; // Standard map end (5828)
   localparam logic [ADDR_W-1:0] EXT_LIMIT = 13'h1704; // Extended map end (5892)
   localparam int unsigned NUM_REGS = 10;          // Registered outputs
   localparam int unsigned POL_BASE = 5808;        // First output polarity fuse
   localparam logic [SIG_BITS-1:0] SIG_BLANK = 64'h0000000000000000; // Erased signature
   localparam logic [NUM_REGS-1:0] REG_RESET = 10'h000; // Registers after reset

   // Programmer command codes
   typedef enum logic [2:0] {
      OP_NOP,
      OP_PROG_BEGIN,
      OP_WRITE,
      OP_PROG_END,
      OP_READ,
      OP_SECURE
   } fssp_op_t;
endpackage

// ---- hdl/fssp_store_if.sv ----
// Purpose: Carrier between the controller and the fuse store.
// Assumes: Same clock on both sides.
// Notes: Erase has priority over write inside the store.
`timescale 1ns/1ps
`default_nettype none
interface fssp_store_if;
   import fssp_pkg::*;
   logic erase;                 // Clear whole array this cycle
   logic wrEn;                  // Program one fuse
   logic [ADDR_W-1:0] addr;     // Fuse address for write and read
   logic wrData;                // Fuse value to write
   logic rdData;                // Fuse value at addr
   logic [SIG_BITS-1:0] sig;    // User signature contents
   logic [NUM_REGS-1:0] pol;    // Output polarity fuses
   modport ctrl (output erase, output wrEn, output addr, output wrData,
                 input rdData, input sig, input pol);
   modport store (input erase, input wrEn, input addr, input wrData,
                  output rdData, output sig, output pol);
endinterface
`default_nettype wire

// ---- hdl/fuse_signature_security_preload.sv ----
// Purpose: Programmer access to fuses, signature and security cell; preloadable output registers.
// Assumes: Command port comes from same-clock programmer logic; test mode comes from a pin.
// Notes: Security cell and fuses are non-volatile and keep their value across reset.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Holds a 64-bit user signature store
// - Signature reads succeed regardless of security
// - Secured device refuses logic array read-back
// - Security clears only by reprogramming device
// - Programming automatically erases the whole array
// - Extended map has 5892 fuses with signature
// - Standard 5828-fuse map is also accepted
// - Test preload synchronously forces registered outputs
// - Power-up reset drives registers low quickly
// - Pins show reset state through polarity
module fuse_signature_security_preload
   import fssp_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic cmdValid,
   output logic cmdReady,
   input wire fssp_op_t cmdOp,
   input wire logic [ADDR_W-1:0] cmdAddr,
   input wire logic cmdData,
   input wire logic mapExtended,
   output logic rspValid,
   output logic rspData,
   output logic rspRefused,
   output logic secured,
   output logic [SIG_BITS-1:0] userSig,
   input wire logic testMode,
   input wire logic preloadStrobe,
   input wire logic [NUM_REGS-1:0] preloadValue,
   input wire logic [NUM_REGS-1:0] regNext,
   input wire logic [NUM_REGS-1:0] regOutEn,
   output logic [NUM_REGS-1:0] regState,
   output logic [NUM_REGS-1:0] pinOut,
   output logic [NUM_REGS-1:0] pinOe
);
   typedef enum {ST_IDLE, ST_PROG} fssp_state_t;

   fssp_store_if st ();                     // Path to fuse store
   fssp_state_t state_ff, nxt_state;        // Programming session state
   logic secure_ff = 1'b0;                  // Security cell, non-volatile
   logic nxt_secure;
   logic extMap_ff, nxt_extMap;             // Session uses extended map
   logic rspValid_ff, nxt_rspValid;         // Answer strobe
   logic rspData_ff, nxt_rspData;           // Answer data
   logic rspRefused_ff, nxt_rspRefused;     // Answer refused flag
   logic [POR_W-1:0] porCnt_ff, nxt_porCnt; // Power-up window counter
   logic porDone_ff, nxt_porDone;           // Power-up window over
   logic tmMeta_ff, tmSync_ff;              // Test mode synchroniser
   logic [NUM_REGS-1:0] macro_ff, nxt_macro;   // Output registers
   logic [NUM_REGS-1:0] pinOut_ff, nxt_pinOut; // Pin levels
   logic [NUM_REGS-1:0] pinOe_ff, nxt_pinOe;   // Pin enables
   logic cmdTaken;                          // Command accepted this cycle
   logic [ADDR_W-1:0] writeLimit;           // End of map for this session

   fssp_fuse_store u_store (
      .mclk (mclk),
      .rst (rst),
      .st (st.store)
   );

   assign cmdReady = porDone_ff;
   assign cmdTaken = cmdValid && porDone_ff;
   assign writeLimit = extMap_ff ? EXT_LIMIT : STD_LIMIT;
   assign st.addr = cmdAddr;
   assign st.wrData = cmdData;

   // Power-up window: count out the reset time after rst
   always_comb begin
      nxt_porCnt = porCnt_ff;
      nxt_porDone = porDone_ff;
      if (rst) begin
         nxt_porCnt = '0;
         nxt_porDone = 1'b0;
      end else if (!porDone_ff) begin
         nxt_porCnt = porCnt_ff + POR_W'(1);
         nxt_porDone = (porCnt_ff == POR_LAST);
      end
   end

   always_ff @(posedge mclk) begin
      porCnt_ff <= nxt_porCnt;
      porDone_ff <= nxt_porDone;
   end

   // Command decode and programming session
   always_comb begin
      nxt_state = state_ff;
      nxt_secure = secure_ff;
      nxt_extMap = extMap_ff;
      nxt_rspValid = 1'b0;
      nxt_rspData = 1'b0;
      nxt_rspRefused = 1'b0;
      st.erase = 1'b0;
      st.wrEn = 1'b0;
      if (rst) begin
         nxt_state = ST_IDLE; // Open session abandoned; cell untouched
         nxt_extMap = 1'b0;
      end else if (cmdTaken && cmdOp != OP_NOP) begin
         nxt_rspValid = 1'b1;
         case (cmdOp)
            OP_PROG_BEGIN: begin
               st.erase = 1'b1;
               nxt_secure = 1'b0;
               nxt_extMap = mapExtended;
               nxt_state = ST_PROG;
            end
            OP_WRITE: begin
               // Only inside a session and within the chosen map
               if (state_ff == ST_PROG && cmdAddr < writeLimit) begin
                  st.wrEn = 1'b1;
               end else begin
                  nxt_rspRefused = 1'b1;
               end
            end
            OP_PROG_END: begin
               if (state_ff == ST_PROG) begin
                  nxt_state = ST_IDLE;
               end else begin
                  nxt_rspRefused = 1'b1;
               end
            end
            OP_READ: begin
               if (state_ff == ST_PROG || cmdAddr >= EXT_LIMIT) begin
                  nxt_rspRefused = 1'b1;
               end else if (cmdAddr < SIG_BASE && secure_ff) begin
                  nxt_rspRefused = 1'b1;
               end else begin
                  nxt_rspData = st.rdData;
               end
            end
            OP_SECURE: begin
               if (state_ff == ST_PROG) begin
                  nxt_rspRefused = 1'b1;
               end else begin
                  nxt_secure = 1'b1;
               end
            end
            default: begin
               nxt_rspRefused = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      state_ff <= nxt_state;
      secure_ff <= nxt_secure;
      extMap_ff <= nxt_extMap;
      rspValid_ff <= nxt_rspValid;
      rspData_ff <= nxt_rspData;
      rspRefused_ff <= nxt_rspRefused;
   end

   // Test mode pin synchroniser
   always_ff @(posedge mclk) begin
      tmMeta_ff <= testMode;
      tmSync_ff <= tmMeta_ff;
   end

   // Output registers: reset, preload, hold or normal feedback
   always_comb begin
      nxt_macro = macro_ff;
      if (rst || !porDone_ff) begin
         nxt_macro = REG_RESET;
      end else if (tmSync_ff) begin
         if (preloadStrobe) begin
            nxt_macro = preloadValue;
         end
      end else begin
         nxt_macro = regNext;
      end
      nxt_pinOut = nxt_macro ^ st.pol;
      nxt_pinOe = rst ? '0 : regOutEn;
   end

   always_ff @(posedge mclk) begin
      macro_ff <= nxt_macro;
      pinOut_ff <= nxt_pinOut;
      pinOe_ff <= nxt_pinOe;
   end

   assign rspValid = rspValid_ff;
   assign rspData = rspData_ff;
   assign rspRefused = rspRefused_ff;
   assign secured = secure_ff;
   assign userSig = st.sig;
   assign regState = macro_ff;
   assign pinOut = pinOut_ff;
   assign pinOe = pinOe_ff;

   // Checks
   sequence s_readArray;
      cmdTaken && cmdOp == OP_READ && state_ff == ST_IDLE && cmdAddr < SIG_BASE && secure_ff;
   endsequence
   sequence s_readSig;
      cmdTaken && cmdOp == OP_READ && state_ff == ST_IDLE && cmdAddr >= SIG_BASE && cmdAddr < EXT_LIMIT;
   endsequence
   sequence s_preloadThenExit;
      (tmSync_ff && preloadStrobe && porDone_ff) ##1 (!tmSync_ff);
   endsequence

   a_secure_blocks_read: assert property (@(posedge mclk) disable iff (rst)
      s_readArray |=> (rspValid && rspRefused && !rspData))
      else $error("secured array read not refused");
   a_sig_always_read: assert property (@(posedge mclk) disable iff (rst)
      s_readSig |=> (rspValid && !rspRefused))
      else $error("signature read refused");
   a_secure_only_prog: assert property (@(posedge mclk) disable iff (rst)
      (secure_ff && !(cmdTaken && cmdOp == OP_PROG_BEGIN)) |=> secure_ff)
      else $error("security cell cleared without programming");
   a_prog_auto_erase: assert property (@(posedge mclk) disable iff (rst)
      (cmdTaken && cmdOp == OP_PROG_BEGIN) |-> st.erase ##1 (!secure_ff && state_ff == ST_PROG && userSig == SIG_BLANK))
      else $error("programming did not erase");
   a_std_map_limit: assert property (@(posedge mclk) disable iff (rst)
      (cmdTaken && cmdOp == OP_WRITE && state_ff == ST_PROG && !extMap_ff && cmdAddr >= STD_LIMIT)
      |-> !st.wrEn ##1 rspRefused)
      else $error("standard map wrote past its end");
   a_ext_sig_write: assert property (@(posedge mclk) disable iff (rst)
      (cmdTaken && cmdOp == OP_WRITE && state_ff == ST_PROG && extMap_ff && cmdAddr < EXT_LIMIT)
      |-> st.wrEn ##1 (rspValid && !rspRefused))
      else $error("extended map write refused");
   a_preload_forces: assert property (@(posedge mclk) disable iff (rst)
      (tmSync_ff && preloadStrobe && porDone_ff) |=> (regState == $past(preloadValue)))
      else $error("preload value not loaded");
   a_resume_from_preload: assert property (@(posedge mclk) disable iff (rst)
      s_preloadThenExit |=> (regState == $past(regNext)))
      else $error("feedback not resumed after test mode");
   a_testmode_holds: assert property (@(posedge mclk) disable iff (rst)
      (tmSync_ff && !preloadStrobe && porDone_ff) |=> $stable(regState))
      else $error("registers moved in test mode without preload");
   a_reset_low: assert property (@(posedge mclk)
      rst |=> (regState == REG_RESET && pinOut == st.pol) [*2])
      else $error("registers not low after reset");
   a_por_window: assert property (@(posedge mclk)
      $fell(rst) |-> !cmdReady [*8])
      else $error("commands accepted inside power-up window");
endmodule
`default_nettype wire

// ---- verification/fssp_programmer_model.sv ----
// Purpose: Programmer model driving command and preload sequences.
// Assumes: Same clock as the device; commands wait for cmdReady.
// Notes: Requests change only at a rising edge; released lines show inverted data.
`timescale 1ns/1ps
`default_nettype none
module fssp_programmer_model
   import fssp_pkg::*;
(
   input wire logic mclk,
   input wire logic cmdReady,
   input wire logic rspValid,
   input wire logic rspData,
   input wire logic rspRefused,
   output var logic cmdValid,
   output var fssp_op_t cmdOp,
   output var logic [ADDR_W-1:0] cmdAddr,
   output var logic cmdData,
   output var logic mapExtended,
   output var logic testMode,
   output var logic preloadStrobe,
   output var logic [NUM_REGS-1:0] preloadValue
);
   // Idle lines at time zero
   initial begin
      cmdValid = 1'b0;
      cmdOp = OP_NOP;
      cmdAddr = '0;
      cmdData = 1'b0;
      mapExtended = 1'b0;
      testMode = 1'b0;
      preloadStrobe = 1'b0;
      preloadValue = '0;
   end

   // One command, held until the taking edge, answer sampled just after it
   task automatic issue(input fssp_op_t op, input logic [ADDR_W-1:0] addr, input logic data,
                        output logic v, output logic r, output logic d);
      while (cmdReady !== 1'b1) @(posedge mclk);
      @(posedge mclk);
      cmdValid <= 1'b1;
      cmdOp <= op;
      cmdAddr <= addr;
      cmdData <= data;
      mapExtended <= data;
      @(posedge mclk);
      cmdValid <= 1'b0;
      cmdAddr <= ~addr;
      cmdData <= ~data;
      #1;
      v = rspValid;
      r = rspRefused;
      d = rspData;
   endtask

   // Enter or leave the dedicated test mode
   task automatic setMode(input logic m);
      @(posedge mclk);
      testMode <= m;
   endtask

   // One-cycle preload strobe
   task automatic strobe(input logic [NUM_REGS-1:0] val);
      @(posedge mclk);
      preloadStrobe <= 1'b1;
      preloadValue <= val;
      @(posedge mclk);
      preloadStrobe <= 1'b0;
      preloadValue <= ~val;
      #1;
   endtask
endmodule
`default_nettype wire

// ---- verification/fuse_signature_security_preload_tb_top.sv ----
// Purpose: Self-checking bench for fuse, signature, security and preload behaviour.
// Assumes: Array blank at start; polarity fuses at 5808 and up.
// Notes: Commands go through the programmer model.
`timescale 1ns/1ps
`default_nettype none
module fuse_signature_security_preload_tb_top
   import fssp_pkg::*;
();
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic cmdValid, cmdReady, cmdData, mapExtended, rspValid, rspData, rspRefused, secured;
   fssp_op_t cmdOp;
   logic [ADDR_W-1:0] cmdAddr;
   logic [SIG_BITS-1:0] userSig;
   logic testMode, preloadStrobe;
   logic [NUM_REGS-1:0] preloadValue, regState, pinOut, pinOe;
   logic [NUM_REGS-1:0] regNext = 10'h3FF; // Logic array feedback
   logic [NUM_REGS-1:0] regOutEn = 10'h3FF; // All pins enabled
   int fails = 0;
   int checked = 0;

   // 50 MHz clock
   always #10 mclk = ~mclk;

   fuse_signature_security_preload u_dut (.mclk(mclk), .rst(rst), .cmdValid(cmdValid), .cmdReady(cmdReady),
      .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData), .mapExtended(mapExtended), .rspValid(rspValid),
      .rspData(rspData), .rspRefused(rspRefused), .secured(secured), .userSig(userSig), .testMode(testMode),
      .preloadStrobe(preloadStrobe), .preloadValue(preloadValue), .regNext(regNext), .regOutEn(regOutEn),
      .regState(regState), .pinOut(pinOut), .pinOe(pinOe));

   fssp_programmer_model u_prog (.mclk(mclk), .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData),
      .rspRefused(rspRefused), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData),
      .mapExtended(mapExtended), .testMode(testMode), .preloadStrobe(preloadStrobe),
      .preloadValue(preloadValue));

   // Verdict and end of run
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Value compare
   task automatic chkVal(input logic [63:0] got, input logic [63:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Command with expected refusal flag and read bit
   task automatic cmd(input fssp_op_t op, input logic [ADDR_W-1:0] a, input logic d, input logic eRef,
                      input logic eDat);
      logic v, r, q;
      u_prog.issue(op, a, d, v, r, q);
      chkVal(64'({v, r, q}), 64'({1'b1, eRef, eDat}), "response");
   endtask

   // Reset, pin state in reset, power-up window length
   task automatic resetDut(input logic [NUM_REGS-1:0] expPin);
      int n;
      @(posedge mclk);
      rst <= 1'b1;
      regNext <= 10'h3FF;
      repeat (12) @(posedge mclk);
      #1;
      chkVal(64'(pinOe), 64'h0, "pinOe in reset");
      chkVal(64'(pinOut), 64'(expPin), "pinOut in reset");
      @(posedge mclk);
      rst <= 1'b0;
      n = 0;
      while (cmdReady !== 1'b1 && n < 200) begin
         @(posedge mclk);
         #1;
         n++;
         if (n == 49) chkVal(64'(regState), 64'h0, "regState in power-up");
      end
      chkVal(64'(n), 64'd50, "power-up cycles");
      @(posedge mclk);
      regNext <= 10'h000;
   endtask

   // Hang guard
   initial begin
      #50000;
      fails++;
      test_done();
   end

   // Main sequence
   initial begin
      resetDut(10'h000);
      cmd(OP_PROG_BEGIN, 13'h0000, 1'b1, 1'b0, 1'b0);
      cmd(OP_WRITE, 13'h16C4, 1'b1, 1'b0, 1'b0);
      cmd(OP_WRITE, 13'h1703, 1'b1, 1'b0, 1'b0);
      cmd(OP_WRITE, 13'h1704, 1'b1, 1'b1, 1'b0);
      cmd(OP_WRITE, 13'h0064, 1'b1, 1'b0, 1'b0);
      cmd(OP_READ, 13'h0064, 1'b0, 1'b1, 1'b0);
      cmd(OP_PROG_END, 13'h0000, 1'b0, 1'b0, 1'b0);
      chkVal(userSig, 64'h8000000000000001, "signature");
      cmd(OP_READ, 13'h0064, 1'b0, 1'b0, 1'b1);
      cmd(OP_SECURE, 13'h0000, 1'b0, 1'b0, 1'b0);
      chkVal(64'(secured), 64'h1, "secured");
      cmd(OP_READ, 13'h0064, 1'b0, 1'b1, 1'b0);
      cmd(OP_READ, 13'h1703, 1'b0, 1'b0, 1'b1);
      cmd(OP_WRITE, 13'h0064, 1'b0, 1'b1, 1'b0);
      cmd(OP_PROG_END, 13'h0000, 1'b0, 1'b1, 1'b0);
      resetDut(10'h000);
      chkVal(64'(secured), 64'h1, "secured after reset");
      chkVal(userSig, 64'h8000000000000001, "signature while secured");
      cmd(OP_PROG_BEGIN, 13'h0000, 1'b0, 1'b0, 1'b0);
      chkVal(64'(secured), 64'h0, "secured after reprogram");
      chkVal(userSig, 64'h0, "signature erased");
      cmd(OP_WRITE, 13'h16C4, 1'b1, 1'b1, 1'b0);
      cmd(OP_WRITE, 13'h16B0, 1'b1, 1'b0, 1'b0);
      cmd(OP_WRITE, 13'h16C3, 1'b1, 1'b0, 1'b0);
      cmd(OP_PROG_END, 13'h0000, 1'b0, 1'b0, 1'b0);
      cmd(OP_READ, 13'h16C3, 1'b0, 1'b0, 1'b1);
      cmd(OP_READ, 13'h0064, 1'b0, 1'b0, 1'b0);
      resetDut(10'h001);
      // Preload in test mode, hold, then resume feedback
      @(posedge mclk);
      regNext <= 10'h0F0;
      u_prog.setMode(1'b1);
      repeat (3) @(posedge mclk);
      u_prog.strobe(10'h2A5);
      chkVal(64'(regState), 64'h2A5, "preloaded state");
      chkVal(64'(pinOut), 64'h2A4, "preloaded pins");
      repeat (3) @(posedge mclk);
      #1;
      chkVal(64'(regState), 64'h2A5, "held in test mode");
      // Last strobe lands on the final synced test-mode edge, then feedback takes over
      u_prog.setMode(1'b0);
      u_prog.strobe(10'h3C3);
      chkVal(64'(regState), 64'h3C3, "last preload before exit");
      repeat (4) @(posedge mclk);
      #1;
      chkVal(64'(regState), 64'h0F0, "feedback resumed");
      chkVal(64'(pinOut), 64'h0F1, "pins follow feedback");
      u_prog.strobe(10'h155);
      chkVal(64'(regState), 64'h0F0, "strobe outside test mode");
      chkVal(64'(pinOe), 64'h3FF, "pins enabled");
      // Per-pin enables follow the request one cycle later
      @(posedge mclk);
      regOutEn <= 10'h30C;
      @(posedge mclk);
      #1;
      chkVal(64'(pinOe), 64'h30C, "pins partly enabled");
      test_done();
   end
endmodule
`default_nettype wire
